// [rtl/mcr_ctrl.sv]
// Clock rate, reset detect, idle, clock-out timer and code-protection control
`timescale 1ns/1ps
module mcr_ctrl (
	// Clock, reset, enable
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	// Register port
	input  wire logic [3:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	// Nonvolatile configuration
	input  wire logic [2:0]  nv_lock_i,
	input  wire logic        nv_double_speed_fuse_i,
	// Board reset pin
	input  wire logic        rst_pin_i,
	output logic             core_reset_o,
	// Core side requests and blocks
	input  wire logic        code_table_read_instr_i,
	input  wire logic        exec_from_external_i,
	input  wire logic        target_internal_i,
	output logic             table_read_block_o,
	input  wire logic        verify_req_i,
	output logic             verify_block_o,
	input  wire logic        ext_fetch_req_i,
	output logic             ext_exec_block_o,
	// Timing outputs and interrupt request input
	output logic             double_speed_o,
	output logic             mc_tick_o,
	output logic             core_en_o,
	output logic             idle_o,
	input  wire logic        irq_pending_i,
	output logic             timer3_irq_o,
	output logic             baud_tick_o,
	// Port 1 pin 0
	input  wire logic        port1_pin0_i,
	output logic             port1_pin0_o,
	output logic             port1_pin0_oe_o
);

	// Effective 6-clock mode from fuse and software bit
	function automatic logic eff_dbl(input logic fuse, input logic sw);
		return fuse | sw;
	endfunction

	logic [2:0]  lock_r;
	logic        fuse_r;
	logic        sw_double_speed_bit_r;
	logic        idle_r;
	logic        t3_csel_r;
	logic        t3_run_r;
	logic        t3_flag_r;
	logic        t3_ckoe_r;
	logic [15:0] reload_r;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic        clkout_r;
	logic [3:0]  presc_r;
	logic [4:0]  rst_cnt_r;
	logic        core_rst_r;
	logic        rpin_s1_r;
	logic        rpin_s2_r;
	logic        p0_s1_r;
	logic        p0_s2_r;
	logic        p0_d_r;
	logic        dbl;
	logic        sfr_rst;
	logic        clkout_mode;
	logic        t3_tick;
	logic        t3_ovf;
	logic [4:0]  rst_lim;
	logic [3:0]  presc_max;

	// Combined reset: pin reset restarts like power-on
	assign sfr_rst     = !nrst_i || core_rst_r;
	assign dbl         = eff_dbl(fuse_r, sw_double_speed_bit_r);
	assign clkout_mode = !t3_csel_r && t3_ckoe_r && t3_run_r;
	assign rst_lim     = dbl ? mcr_pkg::RST_CNT_6 : mcr_pkg::RST_CNT_12;
	assign presc_max   = dbl ? mcr_pkg::PRESC_MAX6 : mcr_pkg::PRESC_MAX12;

	// Nonvolatile bits caught while reset is held; stable through operation
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			lock_r <= nv_lock_i;
			fuse_r <= nv_double_speed_fuse_i;
		end
	end

	// Synchronisers for the two pins
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			rpin_s1_r <= 1'b0;
			rpin_s2_r <= 1'b0;
			p0_s1_r   <= 1'b1;
			p0_s2_r   <= 1'b1;
			p0_d_r    <= 1'b1;
		end else if (ce_i) begin
			rpin_s1_r <= rst_pin_i;
			rpin_s2_r <= rpin_s1_r;
			p0_s1_r   <= port1_pin0_i;
			p0_s2_r   <= p0_s1_r;
			p0_d_r    <= p0_s2_r;
		end
	end

	// Reset pin must stay high for two machine cycles before it counts;
	// a stopped oscillator (ce low) stretches nothing
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			rst_cnt_r  <= 5'h00;
			core_rst_r <= 1'b0;
		end else if (ce_i) begin
			if (!rpin_s2_r) begin
				rst_cnt_r  <= 5'h00;
				core_rst_r <= 1'b0;
			end else if (rst_cnt_r == rst_lim - 5'h01) begin
				core_rst_r <= 1'b1;
			end else begin
				rst_cnt_r <= rst_cnt_r + 5'h01;
			end
		end
	end

	// Machine cycle prescaler; a rate switch moves the wrap point at once, within the current cycle
	always_ff @(posedge mclk_i) begin
		if (sfr_rst) begin
			presc_r <= 4'h0;
		end else if (ce_i) begin
			presc_r <= (presc_r >= presc_max) ? 4'h0 : presc_r + 4'h1;
		end
	end
	assign mc_tick_o = ce_i && (presc_r >= presc_max);

	// Timer ticks at osc/2 in 12-clock mode, osc/1 in 6-clock mode,
	// or on a falling edge of the pin in counter mode
	assign t3_tick = t3_run_r && ce_i &&
		(t3_csel_r ? (p0_d_r && !p0_s2_r) : (dbl || presc_r[0]));
	assign t3_ovf  = t3_tick && (cnt_r == 16'hFFFF);

	// Register writes; idle freezes only the core, not these registers
	always_ff @(posedge mclk_i) begin
		if (sfr_rst) begin
			sw_double_speed_bit_r <= 1'b0;
			t3_csel_r <= 1'b0;
			t3_run_r  <= 1'b0;
			t3_ckoe_r <= 1'b0;
			reload_r  <= 16'h0000;
		end else if (ce_i && wr_i) begin
			unique case (addr_i)
				mcr_pkg::REG_CLKCTL:
					sw_double_speed_bit_r <= wdata_i[mcr_pkg::CLK_DBL_BIT];
				mcr_pkg::REG_T3CTL: begin
					t3_csel_r <= wdata_i[mcr_pkg::T3_CSEL_BIT];
					t3_run_r  <= wdata_i[mcr_pkg::T3_RUN_BIT];
				end
				mcr_pkg::REG_T3MODE:
					t3_ckoe_r <= wdata_i[mcr_pkg::T3_CKOE_BIT];
				mcr_pkg::REG_RELOADL:
					reload_r[7:0] <= wdata_i;
				mcr_pkg::REG_RELOADH:
					reload_r[15:8] <= wdata_i;
				default: ;
			endcase
		end
	end

	// Counter: software load, else count and reload on overflow
	always_comb begin
		cnt_nxt = cnt_r;
		if (t3_ovf) begin
			cnt_nxt = reload_r;
		end else if (t3_tick) begin
			cnt_nxt = cnt_r + 16'h0001;
		end
		if (wr_i && addr_i == mcr_pkg::REG_CNTL) begin
			cnt_nxt[7:0] = wdata_i;
		end
		if (wr_i && addr_i == mcr_pkg::REG_CNTH) begin
			cnt_nxt[15:8] = wdata_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sfr_rst) begin
			cnt_r <= 16'h0000;
		end else if (ce_i) begin
			cnt_r <= cnt_nxt;
		end
	end

	// Overflow flag: suppressed in clock-out mode; set wins over clear
	always_ff @(posedge mclk_i) begin
		if (sfr_rst) begin
			t3_flag_r <= 1'b0;
		end else if (ce_i) begin
			if (t3_ovf && !clkout_mode) begin
				t3_flag_r <= 1'b1;
			end else if (wr_i && addr_i == mcr_pkg::REG_T3CTL &&
				!wdata_i[mcr_pkg::T3_FLAG_BIT]) begin
				t3_flag_r <= 1'b0;
			end
		end
	end
	assign timer3_irq_o = t3_flag_r;
	assign baud_tick_o  = t3_ovf;

	// Square wave: one toggle per overflow gives exactly 50% duty
	always_ff @(posedge mclk_i) begin
		if (sfr_rst) begin
			clkout_r <= 1'b0;
		end else if (ce_i && t3_ovf && clkout_mode) begin
			clkout_r <= !clkout_r;
		end
	end
	assign port1_pin0_o    = clkout_r;
	assign port1_pin0_oe_o = clkout_mode;

	// Idle request; an interrupt or reset ends it, request loses to the wake
	always_ff @(posedge mclk_i) begin
		if (sfr_rst) begin
			idle_r <= 1'b0;
		end else if (ce_i) begin
			if (irq_pending_i) begin
				idle_r <= 1'b0;
			end else if (wr_i && addr_i == mcr_pkg::REG_PWRCTL) begin
				idle_r <= wdata_i[mcr_pkg::PWR_IDLE_BIT];
			end
		end
	end
	// Core clock enable drops right after the requesting write completes
	assign core_en_o      = ce_i && !idle_r && !core_rst_r;
	assign idle_o         = idle_r;
	assign core_reset_o   = core_rst_r;
	assign double_speed_o = dbl;

	// Code protection gates
	assign table_read_block_o = code_table_read_instr_i && exec_from_external_i &&
		target_internal_i && (lock_r[mcr_pkg::LOCK_READ] || lock_r[mcr_pkg::LOCK_EXT]);
	assign verify_block_o   = verify_req_i && lock_r[mcr_pkg::LOCK_VER];
	assign ext_exec_block_o = ext_fetch_req_i && lock_r[mcr_pkg::LOCK_EXT];

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			rdata_o <= mcr_pkg::ZERO8;
		end else if (ce_i) begin
			rdata_o <= mcr_pkg::ZERO8;
			if (rd_i) begin
				unique case (addr_i)
					mcr_pkg::REG_CLKCTL:
						rdata_o[mcr_pkg::CLK_DBL_BIT] <= sw_double_speed_bit_r;
					mcr_pkg::REG_PWRCTL:
						rdata_o[mcr_pkg::PWR_IDLE_BIT] <= idle_r;
					mcr_pkg::REG_T3CTL: begin
						rdata_o[mcr_pkg::T3_CSEL_BIT] <= t3_csel_r;
						rdata_o[mcr_pkg::T3_RUN_BIT]  <= t3_run_r;
						rdata_o[mcr_pkg::T3_FLAG_BIT] <= t3_flag_r;
					end
					mcr_pkg::REG_T3MODE:
						rdata_o[mcr_pkg::T3_CKOE_BIT] <= t3_ckoe_r;
					mcr_pkg::REG_RELOADL:
						rdata_o <= reload_r[7:0];
					mcr_pkg::REG_RELOADH:
						rdata_o <= reload_r[15:8];
					mcr_pkg::REG_CNTL:
						rdata_o <= cnt_r[7:0];
					mcr_pkg::REG_CNTH:
						rdata_o <= cnt_r[15:8];
					mcr_pkg::REG_STATUS: begin
						rdata_o[mcr_pkg::ST_LOCK_LSB +: mcr_pkg::LOCK_N] <= lock_r;
						rdata_o[mcr_pkg::ST_FUSE_BIT] <= fuse_r;
						rdata_o[mcr_pkg::ST_DBL_BIT]  <= dbl;
						rdata_o[mcr_pkg::ST_RST_BIT]  <= core_rst_r;
					end
					default: ;
				endcase
			end
		end
	end

	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	a_fuse_forces_dbl: assert property (fuse_r |-> double_speed_o)
		else $error("fuse programmed but not in 6-clock mode");
	a_sw_rate_sel: assert property (!fuse_r |-> double_speed_o == sw_double_speed_bit_r)
		else $error("clock rate does not follow software bit");
	a_table_lock: assert property ((code_table_read_instr_i && exec_from_external_i &&
		target_internal_i && (lock_r[0] || lock_r[2])) |-> table_read_block_o)
		else $error("table read not blocked under lock");
	a_verify_lock: assert property (verify_req_i |-> verify_block_o == lock_r[1])
		else $error("verify block mismatch");
	a_ext_lock: assert property (ext_fetch_req_i && lock_r[2] |-> ext_exec_block_o)
		else $error("external execution not blocked");
	a_clkout_gate: assert property (port1_pin0_oe_o |->
		(t3_run_r && t3_ckoe_r && !t3_csel_r))
		else $error("clock out driven without enables");
	a_clkout_toggle: assert property (t3_ovf && clkout_mode && !core_rst_r |=>
		port1_pin0_o != $past(port1_pin0_o))
		else $error("clock out missed an overflow");
	a_no_clkout_irq: assert property (t3_ovf && clkout_mode && !t3_flag_r |=>
		!t3_flag_r)
		else $error("interrupt raised in clock-out mode");
	a_reset_hold: assert property ($rose(core_reset_o) |->
		$past(rst_cnt_r) == rst_lim - 5'h01 && $past(rpin_s2_r))
		else $error("reset recognised too early");
	a_idle_core_off: assert property (idle_o |-> !core_en_o)
		else $error("core runs during idle");
	a_idle_wake: assert property (idle_o && irq_pending_i && ce_i |=> !idle_o)
		else $error("interrupt did not end idle");
	a_frozen_state: assert property (!ce_i && !core_rst_r |=>
		$stable(cnt_r) && $stable(idle_r))
		else $error("state moved with clock enable low");

	// Gates stay open when no lock or no request covers the access
	a_table_free: assert property (!lock_r[mcr_pkg::LOCK_READ] &&
		!lock_r[mcr_pkg::LOCK_EXT] |-> !table_read_block_o)
		else $error("table read blocked without a lock");
	a_verify_idle: assert property (!verify_req_i |-> !verify_block_o)
		else $error("verify blocked without a request");
	a_ext_free: assert property (!lock_r[mcr_pkg::LOCK_EXT] |-> !ext_exec_block_o)
		else $error("external execution blocked without a lock");
	// Lock image only moves while the reset input is held
	a_lock_hold: assert property ($past(nrst_i) |->
		$stable(lock_r) && $stable(fuse_r))
		else $error("lock bits changed outside reset");
	// Machine cycle of six enabled clocks in 6-clock mode
	a_tick_six: assert property (mc_tick_o && double_speed_o && !core_rst_r ##1
		(double_speed_o && ce_i && !core_rst_r)[*6] |-> mc_tick_o)
		else $error("6-clock machine cycle is not six clocks");
	a_tick_single: assert property (mc_tick_o |=> !mc_tick_o)
		else $error("machine cycle tick lasted two clocks");
	// Recognition drops as soon as the synced pin is low
	a_reset_release: assert property (!rpin_s2_r && ce_i |=> !core_reset_o)
		else $error("reset held after the pin went low");
	// Pin reset restores the control state as power-on does
	a_pin_reset_regs: assert property (core_reset_o |=>
		!idle_o && !t3_run_r && !sw_double_speed_bit_r && cnt_r == 16'h0000)
		else $error("pin reset left control state behind");
	a_core_en_rst: assert property (core_reset_o |-> !core_en_o)
		else $error("core enabled during pin reset");
	// Counter steps by one per tick and reloads on overflow, unless software loads it
	a_cnt_step: assert property (t3_tick && !t3_ovf && !core_rst_r &&
		!(wr_i && (addr_i == mcr_pkg::REG_CNTL || addr_i == mcr_pkg::REG_CNTH)) |=>
		cnt_r == $past(cnt_r) + 16'h0001)
		else $error("counter did not step on a tick");
	a_cnt_reload: assert property (t3_ovf && !core_rst_r &&
		!(wr_i && (addr_i == mcr_pkg::REG_CNTL || addr_i == mcr_pkg::REG_CNTH)) |=>
		cnt_r == $past(reload_r))
		else $error("counter did not reload on overflow");
	// Outside clock-out mode an overflow raises the flag, set beats clear
	a_flag_set: assert property (t3_ovf && !clkout_mode && !core_rst_r |=> t3_flag_r)
		else $error("overflow flag not raised");
	// The pin only moves on an overflow in clock-out mode
	a_clkout_hold: assert property (!(t3_ovf && clkout_mode) && !core_rst_r |=>
		$stable(port1_pin0_o))
		else $error("clock out moved without an overflow");
	a_clkout_oe: assert property (clkout_mode |-> port1_pin0_oe_o)
		else $error("clock out mode but pin not driven");
	// An idle write takes effect unless a wake is pending in the same cycle
	a_idle_enter: assert property (ce_i && wr_i && addr_i == mcr_pkg::REG_PWRCTL &&
		wdata_i[mcr_pkg::PWR_IDLE_BIT] && !irq_pending_i && !core_rst_r |=> idle_o)
		else $error("idle request not taken");

	c_idle_enter: cover property (!idle_o ##1 idle_o);
	c_clkout_tog: cover property (clkout_mode && t3_ovf);
	c_reset_seen: cover property ($rose(core_reset_o));
	c_idle_reset: cover property (idle_o ##1 core_reset_o);
	c_count_pin: cover property (t3_csel_r && t3_tick);

endmodule

// [rtl/mcr_pkg.sv]
// Constants for the clock, reset, idle and code-protection control block
package mcr_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	// Register indices
	localparam logic [3:0] REG_CLKCTL  = 4'h0;
	localparam logic [3:0] REG_PWRCTL  = 4'h1;
	localparam logic [3:0] REG_T3CTL   = 4'h2;
	localparam logic [3:0] REG_T3MODE  = 4'h3;
	localparam logic [3:0] REG_RELOADL = 4'h4;
	localparam logic [3:0] REG_RELOADH = 4'h5;
	localparam logic [3:0] REG_CNTL    = 4'h6;
	localparam logic [3:0] REG_CNTH    = 4'h7;
	localparam logic [3:0] REG_STATUS  = 4'h8;
	// Field positions
	localparam int CLK_DBL_BIT  = 0;
	localparam int PWR_IDLE_BIT = 0;
	localparam int T3_CSEL_BIT  = 1;
	localparam int T3_RUN_BIT   = 2;
	localparam int T3_FLAG_BIT  = 7;
	localparam int T3_CKOE_BIT  = 1;
	localparam int ST_LOCK_LSB  = 0;
	localparam int ST_FUSE_BIT  = 3;
	localparam int ST_DBL_BIT   = 4;
	localparam int ST_RST_BIT   = 5;
	// Lock bit positions
	localparam int LOCK_READ = 0;
	localparam int LOCK_VER  = 1;
	localparam int LOCK_EXT  = 2;
	localparam int LOCK_N    = 3;
	// Timing in oscillator periods
	localparam int RST_MC_N    = 2;
	localparam int OSC_PER_MC12 = 12;
	localparam int OSC_PER_MC6  = 6;
	localparam logic [4:0] RST_CNT_12 = 5'(RST_MC_N * OSC_PER_MC12);
	localparam logic [4:0] RST_CNT_6  = 5'(RST_MC_N * OSC_PER_MC6);
	localparam logic [3:0] PRESC_MAX12 = 4'(OSC_PER_MC12 - 1);
	localparam logic [3:0] PRESC_MAX6  = 4'(OSC_PER_MC6 - 1);
	localparam logic [7:0] ZERO8 = 8'h00;
endpackage

// [verification/mcr_board.sv]
// Board reset source and programmer image of the lock bits and speed fuse
`timescale 1ns/1ps
module mcr_board (
	// Clock and commands from the bench
	input  wire logic       mclk_i,
	input  wire logic       go_i,
	input  wire logic [7:0] len_i,
	input  wire logic [2:0] lock_set_i,
	input  wire logic       fuse_set_i,
	// Device pins
	output logic            rst_pin_o,
	output logic [2:0]      nv_lock_o,
	output logic            nv_double_speed_fuse_o
);
	// Power-up hold covers oscillator startup plus two machine cycles
	logic [7:0] left_r = 8'h28;
	// Reset pulse of the commanded length; short ones test the refusal
	always @(posedge mclk_i) begin
		if (go_i) begin
			left_r <= len_i;
		end else if (left_r != 8'h00) begin
			left_r <= left_r - 8'h01;
		end
	end
	assign rst_pin_o = (left_r != 8'h00);
	// Programmer sets each lock and the fuse independently
	assign nv_lock_o = lock_set_i;
	assign nv_double_speed_fuse_o = fuse_set_i;
endmodule

// [verification/tb.sv]
// Self-checking bench for the clock, reset, idle and protection block
`timescale 1ns/1ps
module tb;
	logic       mclk_i = 1'b0;
	logic       nrst_i = 1'b0;
	logic       ce_i = 1'b1;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic       req = 1'b1;
	logic       irq = 1'b0;
	logic       go = 1'b0;
	logic [7:0] len = 8'h00;
	logic [2:0] lock_set = 3'h0;
	logic       fuse_set = 1'b0;
	logic       p0 = 1'b1;
	logic [7:0] rdata_o;
	logic [2:0] nv_lock;
	logic       fuse, rst_pin, core_rst, tblk, vblk, xblk, dbl, tick, cen, idle;
	logic       t3irq, baud, pin, pin_oe, l;
	logic [7:0] d;
	int         miscompares = 0;
	int         comparisons = 0;
	int         g, n, c;
	// Pulse length, speed bit, expected recognition
	int         lens[4] = '{23, 30, 11, 14};
	logic [3:0] dbs = 4'b1100;
	logic [3:0] rex = 4'b1010;
	// Clock 25 MHz
	always #20 mclk_i = ~mclk_i;
	mcr_board i_mcr_board (.mclk_i(mclk_i), .go_i(go), .len_i(len), .lock_set_i(lock_set),
		.fuse_set_i(fuse_set), .rst_pin_o(rst_pin), .nv_lock_o(nv_lock),
		.nv_double_speed_fuse_o(fuse));
	mcr_ctrl i_mcr_ctrl (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .nv_lock_i(nv_lock),
		.nv_double_speed_fuse_i(fuse), .rst_pin_i(rst_pin), .core_reset_o(core_rst),
		.code_table_read_instr_i(req), .exec_from_external_i(req), .target_internal_i(req),
		.table_read_block_o(tblk), .verify_req_i(req), .verify_block_o(vblk),
		.ext_fetch_req_i(req), .ext_exec_block_o(xblk), .double_speed_o(dbl),
		.mc_tick_o(tick), .core_en_o(cen), .idle_o(idle), .irq_pending_i(irq),
		.timer3_irq_o(t3irq), .baud_tick_o(baud), .port1_pin0_i(p0),
		.port1_pin0_o(pin), .port1_pin0_oe_o(pin_oe));
	task automatic wrap_up();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	task automatic pulse(input logic [7:0] v);
		@(posedge mclk_i);
		len <= v;
		go <= 1'b1;
		@(posedge mclk_i);
		go <= 1'b0;
		#1;
	endtask
	// Bounded wait until the pin and the recognised reset are both gone
	task automatic wait_quiet();
		int k;
		for (k = 0; k < 200 && (rst_pin !== 1'b0 || core_rst !== 1'b0); k++)
			@(posedge mclk_i);
		if (k == 200) begin
			miscompares++;
			wrap_up();
		end
	endtask
	task automatic do_reset();
		@(posedge mclk_i);
		nrst_i <= 1'b0;
		repeat (6) @(posedge mclk_i);
		nrst_i <= 1'b1;
		wait_quiet();
	endtask
	// Cycles between events; the first interval is skipped as it may straddle a change
	task automatic gap(input bit p, output int cnt);
		int k;
		int s;
		logic ev;
		s = 0;
		cnt = 0;
		l = pin;
		for (k = 0; k < 400; k++) begin
			@(posedge mclk_i);
			#1 cnt++;
			ev = p ? (pin !== l) : (tick === 1'b1);
			l = pin;
			if (ev) begin
				s++;
				if (s == 3) return;
				cnt = 0;
			end
		end
		miscompares++;
		wrap_up();
	endtask
	initial begin
		// Every lock combination, fuse following the low lock bit
		for (n = 0; n < 8; n++) begin
			lock_set <= n[2:0];
			fuse_set <= n[0];
			do_reset();
			rd(4'h8, d);
			chk("status", {3'b000, n[0], n[0], n[2:0]}, {2'b00, d[5:0]});
			chk("table_block", 8'(n[0] | n[2]), 8'(tblk));
			chk("verify_block", 8'(n[1]), 8'(vblk));
			chk("ext_block", 8'(n[2]), 8'(xblk));
			req <= 1'b0;
			#1 chk("no_request_block", 8'h00, {5'h00, tblk, vblk, xblk});
			req <= 1'b1;
			wr(4'h0, 8'h00);
			chk("double_speed", 8'(n[0]), 8'(dbl));
			gap(0, g);
			chk("tick_gap", n[0] ? 8'h06 : 8'h0C, 8'(g));
		end
		lock_set <= 3'h0;
		fuse_set <= 1'b0;
		do_reset();
		wr(4'h0, 8'h01);
		chk("double_speed", 8'h01, 8'(dbl));
		gap(0, g);
		chk("tick_gap", 8'h06, 8'(g));
		// Reset pin: short pulses refused, long ones recognised in either mode
		for (n = 0; n < 4; n++) begin
			wr(4'h0, 8'(dbs[n]));
			pulse(8'(lens[n]));
			c = 0;
			repeat (60) @(posedge mclk_i) c = c | int'(core_rst === 1'b1);
			chk("reset_seen", 8'(rex[n]), 8'(c));
			wait_quiet();
		end
		rd(4'h0, d);
		chk("clkctl_after_pin_reset", 8'h00, d);
		// Clock out, reload FFFE: toggle every 4 clocks in 12-clock mode
		wr(4'h6, 8'hFE);
		wr(4'h7, 8'hFF);
		wr(4'h4, 8'hFE);
		wr(4'h5, 8'hFF);
		wr(4'h3, 8'h02);
		wr(4'h2, 8'h04);
		gap(1, g);
		chk("clkout_half", 8'h04, 8'(g));
		chk("clkout_oe", 8'h01, 8'(pin_oe));
		c = 0;
		repeat (40) @(posedge mclk_i) c = c + int'(baud === 1'b1);
		chk("baud_count", 8'h0A, 8'(c));
		rd(4'h2, d);
		chk("timer_flag", 8'h00, {7'h00, d[7]});
		chk("timer_irq", 8'h00, 8'(t3irq));
		wr(4'h0, 8'h01);
		gap(1, g);
		chk("clkout_half", 8'h02, 8'(g));
		// Stopped oscillator freezes everything
		l = pin;
		ce_i <= 1'b0;
		c = 0;
		repeat (20) @(posedge mclk_i) c = c + int'(tick === 1'b1);
		chk("frozen_ticks", 8'h00, 8'(c));
		chk("frozen_pin", 8'(l), 8'(pin));
		ce_i <= 1'b1;
		// Idle: core stops, timer runs, interrupt wakes
		wr(4'h1, 8'h01);
		#1 chk("idle", 8'h01, 8'(idle));
		chk("core_en", 8'h00, 8'(cen));
		rd(4'h5, d);
		chk("reload_high", 8'hFF, d);
		gap(1, g);
		chk("idle_clkout", 8'h02, 8'(g));
		irq <= 1'b1;
		repeat (2) @(posedge mclk_i);
		#1 chk("idle_wake", 8'h00, 8'(idle));
		irq <= 1'b0;
		// Pin reset during idle restarts as from power-on
		wr(4'h1, 8'h01);
		pulse(8'h1E);
		wait_quiet();
		chk("idle_reset", 8'h00, 8'(idle));
		rd(4'h2, d);
		chk("t3ctl_reset", 8'h00, d);
		// Clock out refused unless all three conditions hold
		for (n = 0; n < 3; n++) begin
			wr(4'h3, n == 2 ? 8'h00 : 8'h02);
			wr(4'h2, n == 0 ? 8'h06 : (n == 1 ? 8'h00 : 8'h04));
			chk("clkout_oe_off", 8'h00, 8'(pin_oe));
		end
		// Counter mode: falling pin edges count, overflow raises the flag
		wr(4'h2, 8'h06);
		wr(4'h6, 8'hFE);
		wr(4'h7, 8'hFF);
		for (n = 0; n < 3; n++) begin
			p0 <= 1'b0;
			repeat (4) @(posedge mclk_i);
			p0 <= 1'b1;
			repeat (4) @(posedge mclk_i);
		end
		chk("counter_oe", 8'h00, 8'(pin_oe));
		rd(4'h6, d);
		chk("counter_low", 8'h01, d);
		chk("flag_set", 8'h01, 8'(t3irq));
		wr(4'h2, 8'h06);
		chk("flag_clear", 8'h00, 8'(t3irq));
		wrap_up();
	end
endmodule
